//--- hw/mfr_fault_response.sv
// Purpose: fault response configuration and power stage / indicator control
// Assumes: event inputs are synchronous one-cycle pulses from the detectors
// Notes:   config word arrives through the host port front end
//
// Functional notes
// R1: interval code 0 = 300 ms, 1 = 500 ms, 2..F = 1..14 s.
// R2: checksum mode 0: error latches fault, indicator on, stage tristated.
// R3: checksum mode 1: error only reported on indicator, stage keeps running.
// R4: stall codes 0-2 latch fault, indicator on; tristate, low or high brake.
// R5: code 3 auto-clears after interval; beyond retry limit latches tristated.
// R6: code 4 auto-clears after interval; low brake while fault active.
// R7: code 5 auto-clears; beyond retry limit latches with high brake.
// R8: code 6 reports lock on indicator only, drive unchanged.
// R9: code 7 ignores lock detection entirely.
// R10: bit 2 enables the position detection timeout fault.
// R11: bit 1 enables the position detection rate fault.
// R12: bit 0 enables current and speed loop saturation indication.
// R13: latched faults hold action and indicator until host clear or reset.
`timescale 1ns/1ps
`default_nettype none
module mfr_fault_response #(
  parameter int RETRY_T0_CYC   = mfr_pkg::RETRY_T0_CYC,
  parameter int RETRY_T1_CYC   = mfr_pkg::RETRY_T1_CYC,
  parameter int RETRY_STEP_CYC = mfr_pkg::RETRY_STEP_CYC
) (
  input  wire logic                         sys_clk,
  input  wire logic                         rst_n,
  input  wire logic                         cfg_wr_en,
  input  wire logic [mfr_pkg::DATA_W-1:0]   cfg_wr_data,
  output logic      [mfr_pkg::DATA_W-1:0]   cfg_rd_data,
  input  wire logic [mfr_pkg::RCNT_W-1:0]   retry_count_limit,
  input  wire logic                         fault_clear,
  input  wire logic                         lock_detect,
  input  wire logic                         i2c_crc_err,
  input  wire logic                         pos_detect_timeout,
  input  wire logic                         pos_detect_rate_err,
  input  wire logic                         current_loop_sat,
  input  wire logic                         speed_loop_sat,
  output logic                              fault_indicator_out_n,
  output logic                              stage_tristate,
  output logic                              stage_low_brake,
  output logic                              stage_high_brake,
  output logic                              current_sat_flag,
  output logic                              speed_sat_flag,
  output logic      [mfr_pkg::RCNT_W-1:0]   retry_count,
  output logic      [1:0]                   lock_state,
  output logic      [mfr_pkg::FLG_N-1:0]    fault_sources
);
  typedef struct packed {
    logic [mfr_pkg::CFG_W-1:0]  cfg;
    mfr_pkg::mfr_lock_e         lk;
    mfr_pkg::mfr_drive_e        lk_drv;
    logic [mfr_pkg::RCNT_W-1:0] rcnt;
    logic                       flt_n;
    logic                       tri_o;
    logic                       low_o;
    logic                       high_o;
    logic [1:0]                 sat;
  } mfr_main_s;

  localparam mfr_main_s MAIN_RST = '{
    cfg:    mfr_pkg::CFG_RESET,
    lk:     mfr_pkg::LK_IDLE,
    lk_drv: mfr_pkg::DRV_RUN,
    rcnt:   '0,
    flt_n:  1'b1,
    tri_o:  1'b0,
    low_o:  1'b0,
    high_o: 1'b0,
    sat:    2'h0
  };

  mfr_main_s            q;
  mfr_main_s            d;
  mfr_pkg::mfr_stall_e  stall;
  mfr_pkg::mfr_drive_e  drv;
  logic [mfr_pkg::RETRY_W-1:0] retry_code;
  logic                 crc_report_only;
  logic                 lock_hit;
  logic                 any_tri_flag;

  mfr_timer_if tif ();
  mfr_flag_if #(.N(mfr_pkg::FLG_N)) fif ();

  mfr_retry_timer u_timer (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .tif     (tif)
  );

  mfr_flag_bank #(.N(mfr_pkg::FLG_N)) u_flags (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .fif     (fif)
  );

  // interval code to cycles; multiply kept in 32 bits (14 s fits)
  function automatic logic [mfr_pkg::TMR_W-1:0] interval_cyc(
    input logic [mfr_pkg::RETRY_W-1:0] code
  );
    logic [mfr_pkg::TMR_W-1:0] secs;
    secs = mfr_pkg::TMR_W'(code - mfr_pkg::RETRY_SEC_BASE);
    if (code == mfr_pkg::RETRY_CODE_T0) begin
      interval_cyc = mfr_pkg::TMR_W'(RETRY_T0_CYC); // R1
    end else if (code == mfr_pkg::RETRY_CODE_T1) begin
      interval_cyc = mfr_pkg::TMR_W'(RETRY_T1_CYC); // R1
    end else begin
      interval_cyc = mfr_pkg::TMR_W'(secs * RETRY_STEP_CYC); // R1
    end
  endfunction

  // brake or tristate action that a stall code calls for
  function automatic mfr_pkg::mfr_drive_e stall_drive(
    input mfr_pkg::mfr_stall_e m
  );
    case (m)
      mfr_pkg::STALL_LATCH_TRI,
      mfr_pkg::STALL_RETRY_TRI:  stall_drive = mfr_pkg::DRV_TRI;
      mfr_pkg::STALL_LATCH_LOW,
      mfr_pkg::STALL_RETRY_LOW:  stall_drive = mfr_pkg::DRV_LOW;
      mfr_pkg::STALL_LATCH_HIGH,
      mfr_pkg::STALL_RETRY_HIGH: stall_drive = mfr_pkg::DRV_HIGH;
      default:                   stall_drive = mfr_pkg::DRV_RUN;
    endcase
  endfunction

  // config field decode from the stored word
  assign retry_code = q.cfg[mfr_pkg::RETRY_LSB +: mfr_pkg::RETRY_W];
  assign stall = mfr_pkg::mfr_stall_e'(
                   q.cfg[mfr_pkg::STALL_LSB +: mfr_pkg::STALL_W]);
  assign crc_report_only = q.cfg[mfr_pkg::CRC_MODE_BIT];
  assign lock_hit = lock_detect & (stall != mfr_pkg::STALL_OFF); // R9

  // sticky sources: checksum goes to exactly one of latch or report
  always_comb begin
    fif.set = '0;
    fif.en  = '0;
    fif.set[mfr_pkg::FLG_CRC_LATCH] = i2c_crc_err;
    fif.set[mfr_pkg::FLG_CRC_RPT]   = i2c_crc_err;
    fif.set[mfr_pkg::FLG_POS_TMO]   = pos_detect_timeout;
    fif.set[mfr_pkg::FLG_POS_RATE]  = pos_detect_rate_err;
    fif.en[mfr_pkg::FLG_CRC_LATCH]  = ~crc_report_only; // R2
    fif.en[mfr_pkg::FLG_CRC_RPT]    = crc_report_only; // R3
    fif.en[mfr_pkg::FLG_POS_TMO]    = q.cfg[mfr_pkg::POS_TMO_BIT]; // R10
    fif.en[mfr_pkg::FLG_POS_RATE]   = q.cfg[mfr_pkg::POS_RATE_BIT]; // R11
    fif.clr = fault_clear; // R13
  end

  assign tif.load = interval_cyc(retry_code);
  assign any_tri_flag = |(fif.flags & mfr_pkg::FLG_TRI_MASK);

  // how the lock path behaves, seen from the power stage:
  //  - idle: drive runs, indicator follows only the sticky flags
  //  - latched kinds (codes 0-2) go straight to the latched state and
  //    hold their brake or tristate until the host clears
  //  - retry kinds (codes 3-5) start the interval timer and count one
  //    retry; the brake or tristate holds while the timer runs
  //  - when the timer expires the drive is released again, but the
  //    retry count stays, so repeated stalls use up the allowance
  //  - once the count has reached the limit the next stall latches
  //    with the same action that the retries used
  //  - the retry count is only cleared by the host clear, never by
  //    a successful restart; a motor that stalls rarely but steadily
  //    therefore ends latched, which is the safer side to fail on
  //  - report kind (code 6) only pulls the indicator low; it is
  //    sticky like the report-only checksum flag
  //  - code 7 masks the detector before anything else looks at it
  //
  // hazards and trade-offs:
  //  - a config write while a retry runs changes the action only at
  //    the next stall; the running interval keeps its old length,
  //    since the load value is taken at the start pulse
  //  - lock pulses while the state is not idle are ignored, except
  //    that they block a clear in the same cycle; a held detector
  //    therefore keeps the fault, which is what the clear should see
  //  - stage outputs are decoded from one drive value, so at most one
  //    of tristate, low brake and high brake is ever high
  //  - a latched checksum or position fault wins over any brake: the
  //    tristate is the only action that is safe for every cause
  //  - indicator and stage outputs come from flip-flops, so a lock is
  //    seen one edge after the event, a sticky flag two edges after
  //
  // lock state machine plus registered outputs; a lock event in the
  // clear cycle keeps the fault so the event is never dropped
  always_comb begin
    d         = q;
    tif.start = 1'b0;
    drv       = mfr_pkg::DRV_RUN;
    if (cfg_wr_en) begin
      d.cfg = cfg_wr_data[mfr_pkg::CFG_W-1:0];
    end
    case (q.lk)
      mfr_pkg::LK_IDLE: begin
        if (lock_hit) begin
          case (stall)
            mfr_pkg::STALL_LATCH_TRI,
            mfr_pkg::STALL_LATCH_LOW,
            mfr_pkg::STALL_LATCH_HIGH: begin
              d.lk     = mfr_pkg::LK_LATCHED; // R4
              d.lk_drv = stall_drive(stall); // R4
            end
            mfr_pkg::STALL_RETRY_TRI,
            mfr_pkg::STALL_RETRY_LOW,
            mfr_pkg::STALL_RETRY_HIGH: begin
              d.lk_drv = stall_drive(stall); // R5 R6 R7
              if (q.rcnt >= retry_count_limit) begin
                d.lk = mfr_pkg::LK_LATCHED; // R5 R7
              end else begin
                d.lk      = mfr_pkg::LK_RETRY; // R6
                d.rcnt    = q.rcnt + 4'h1;
                tif.start = 1'b1;
              end
            end
            mfr_pkg::STALL_REPORT: begin
              d.lk     = mfr_pkg::LK_REPORT; // R8
              d.lk_drv = mfr_pkg::DRV_RUN; // R8
            end
            default: begin
              d.lk = mfr_pkg::LK_IDLE;
            end
          endcase
        end else if (fault_clear) begin
          d.rcnt = '0;
        end
      end
      mfr_pkg::LK_RETRY: begin
        if (fault_clear && !lock_hit) begin
          d.lk     = mfr_pkg::LK_IDLE;
          d.lk_drv = mfr_pkg::DRV_RUN;
          d.rcnt   = '0;
        end else if (tif.expire) begin
          d.lk     = mfr_pkg::LK_IDLE; // R5 R6 R7
          d.lk_drv = mfr_pkg::DRV_RUN;
        end
      end
      mfr_pkg::LK_LATCHED,
      mfr_pkg::LK_REPORT: begin
        if (fault_clear && !lock_hit) begin
          d.lk     = mfr_pkg::LK_IDLE; // R13
          d.lk_drv = mfr_pkg::DRV_RUN;
          d.rcnt   = '0;
        end
      end
      default: begin
        d.lk = mfr_pkg::LK_IDLE;
      end
    endcase

    // latched non-lock faults force tristate over any brake
    drv = any_tri_flag ? mfr_pkg::DRV_TRI : d.lk_drv; // R2 R13
    d.flt_n  = ~((|fif.flags) | (d.lk != mfr_pkg::LK_IDLE)); // R3 R8
    d.tri_o  = (drv == mfr_pkg::DRV_TRI);
    d.low_o  = (drv == mfr_pkg::DRV_LOW);
    d.high_o = (drv == mfr_pkg::DRV_HIGH);
    d.sat    = {speed_loop_sat, current_loop_sat}
               & {2{q.cfg[mfr_pkg::SAT_EN_BIT]}}; // R12
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= MAIN_RST;
    end else begin
      q <= d;
    end
  end

  // all outputs straight from flip-flops
  assign cfg_rd_data = {{(mfr_pkg::DATA_W - mfr_pkg::CFG_W){1'b0}}, q.cfg};
  assign fault_indicator_out_n = q.flt_n;
  assign stage_tristate   = q.tri_o;
  assign stage_low_brake  = q.low_o;
  assign stage_high_brake = q.high_o;
  assign current_sat_flag = q.sat[0];
  assign speed_sat_flag   = q.sat[1];
  assign retry_count      = q.rcnt;
  assign lock_state       = q.lk;
  assign fault_sources    = fif.flags;
endmodule
`default_nettype wire

//--- hw/mfr_pkg.sv
// Purpose: shared constants and types for the motor fault response block
// Assumes: 40 MHz system clock
// Notes:   config field layout, retry interval timing, state encodings
`default_nettype none
package mfr_pkg;
  // clock and retry interval timing
  localparam int CLK_HZ         = 40_000_000;
  localparam int CYC_PER_MS     = CLK_HZ / 1000;
  localparam int RETRY_T0_MS    = 300;
  localparam int RETRY_T1_MS    = 500;
  localparam int RETRY_STEP_MS  = 1000;
  localparam int RETRY_T0_CYC   = RETRY_T0_MS * CYC_PER_MS;
  localparam int RETRY_T1_CYC   = RETRY_T1_MS * CYC_PER_MS;
  localparam int RETRY_STEP_CYC = RETRY_STEP_MS * CYC_PER_MS;
  localparam int TMR_W          = 32;

  // config register layout (bits above CFG_W read as zero)
  localparam int DATA_W       = 32;
  localparam int CFG_W        = 11;
  localparam int RETRY_LSB    = 7;
  localparam int RETRY_W      = 4;
  localparam int CRC_MODE_BIT = 6;
  localparam int STALL_LSB    = 3;
  localparam int STALL_W      = 3;
  localparam int POS_TMO_BIT  = 2;
  localparam int POS_RATE_BIT = 1;
  localparam int SAT_EN_BIT   = 0;
  localparam logic [CFG_W-1:0] CFG_RESET = 11'h000;

  // interval codes: 0 and 1 fixed, above that seconds = code - 1
  localparam logic [RETRY_W-1:0] RETRY_CODE_T0  = 4'h0;
  localparam logic [RETRY_W-1:0] RETRY_CODE_T1  = 4'h1;
  localparam logic [RETRY_W-1:0] RETRY_SEC_BASE = 4'h1;
  localparam int RCNT_W = 4;

  // latched or reported fault sources
  localparam int FLG_CRC_LATCH = 0;
  localparam int FLG_CRC_RPT   = 1;
  localparam int FLG_POS_TMO   = 2;
  localparam int FLG_POS_RATE  = 3;
  localparam int FLG_N         = 4;
  localparam logic [FLG_N-1:0] FLG_TRI_MASK = 4'hd;

  typedef enum logic [2:0] {
    STALL_LATCH_TRI  = 3'b000,
    STALL_LATCH_LOW  = 3'b001,
    STALL_LATCH_HIGH = 3'b010,
    STALL_RETRY_TRI  = 3'b011,
    STALL_RETRY_LOW  = 3'b100,
    STALL_RETRY_HIGH = 3'b101,
    STALL_REPORT     = 3'b110,
    STALL_OFF        = 3'b111
  } mfr_stall_e;

  typedef enum logic [1:0] {
    DRV_RUN  = 2'b00,
    DRV_TRI  = 2'b01,
    DRV_LOW  = 2'b10,
    DRV_HIGH = 2'b11
  } mfr_drive_e;

  typedef enum logic [1:0] {
    LK_IDLE    = 2'b00,
    LK_RETRY   = 2'b01,
    LK_LATCHED = 2'b10,
    LK_REPORT  = 2'b11
  } mfr_lock_e;
endpackage
`default_nettype wire

//--- hw/mfr_ifs.sv
// Purpose: carriers between the fault response core and its helpers
// Assumes: all users on sys_clk
// Notes:   timer start is a one-cycle pulse, expire likewise
`timescale 1ns/1ps
`default_nettype none
interface mfr_timer_if;
  logic                     start;
  logic [mfr_pkg::TMR_W-1:0] load;
  logic                     expire;
  modport ctl (output start, output load, input expire);
  modport tmr (input start, input load, output expire);
endinterface

interface mfr_flag_if #(parameter int N = mfr_pkg::FLG_N);
  logic [N-1:0] set;
  logic [N-1:0] en;
  logic         clr;
  logic [N-1:0] flags;
  modport src  (output set, output en, output clr, input flags);
  modport bank (input set, input en, input clr, output flags);
endinterface
`default_nettype wire

//--- hw/mfr_retry_timer.sv
// Purpose: one-shot down counter timing the lock retry interval
// Assumes: load is at least one cycle
// Notes:   a new start reloads, so no stale expiry can follow it
`timescale 1ns/1ps
`default_nettype none
module mfr_retry_timer (
  input wire logic sys_clk,
  input wire logic rst_n,
  mfr_timer_if.tmr tif
);
  typedef struct packed {
    logic [mfr_pkg::TMR_W-1:0] cnt;
    logic                      run;
    logic                      exp;
  } mfr_tmr_s;

  mfr_tmr_s q;
  mfr_tmr_s d;

  // count down; expire pulses for one cycle as the count runs out
  always_comb begin
    d     = q;
    d.exp = 1'b0;
    if (tif.start) begin
      d.cnt = tif.load;
      d.run = 1'b1;
    end else if (q.run) begin
      if (q.cnt <= 32'h0000_0001) begin
        d.run = 1'b0;
        d.exp = 1'b1;
      end else begin
        d.cnt = q.cnt - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tif.expire = q.exp;
endmodule
`default_nettype wire

//--- hw/mfr_flag_bank.sv
// Purpose: sticky fault flags, one per source, with a shared clear
// Assumes: set and clear are synchronous single-cycle strobes
// Notes:   a set in the clear cycle survives, so no event is lost
`timescale 1ns/1ps
`default_nettype none
module mfr_flag_bank #(
  parameter int N = mfr_pkg::FLG_N
) (
  input wire logic  sys_clk,
  input wire logic  rst_n,
  mfr_flag_if.bank  fif
);
  typedef struct packed {
    logic [N-1:0] f;
  } mfr_flag_s;

  mfr_flag_s    q;
  mfr_flag_s    d;
  logic [N-1:0] nxt;

  // per source: gated set wins over the clear
  for (genvar gi = 0; gi < N; gi++) begin : g_bit
    assign nxt[gi] = (fif.set[gi] & fif.en[gi]) | (q.f[gi] & ~fif.clr);
  end

  always_comb begin
    d   = q;
    d.f = nxt;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign fif.flags = q.f;
endmodule
`default_nettype wire

//--- tb/mfr_fault_response_assertions.sv
// Purpose: port level checks of the fault response block
// Assumes: one sys_clk domain, rst_n async active low
// Notes:   cfg_rd_data is the stored word the logic acts on
`timescale 1ns/1ps
`default_nettype none
module mfr_fault_response_chk (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [31:0] cfg_rd_data,
  input wire logic        fault_clear,
  input wire logic        lock_detect,
  input wire logic        i2c_crc_err,
  input wire logic        pos_detect_timeout,
  input wire logic        pos_detect_rate_err,
  input wire logic        current_loop_sat,
  input wire logic        fault_indicator_out_n,
  input wire logic        stage_tristate,
  input wire logic        stage_low_brake,
  input wire logic        stage_high_brake,
  input wire logic        current_sat_flag,
  input wire logic        speed_sat_flag,
  input wire logic [1:0]  lock_state,
  input wire logic [3:0]  fault_sources
);
  // every check sits on the one clock and drops out under reset
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  crc_latch_a:
    assert property (i2c_crc_err && !cfg_rd_data[6] |=> fault_sources[0]
      ##1 (stage_tristate && !fault_indicator_out_n)) else $error("crc latch");
  crc_report_a:
    assert property (i2c_crc_err && cfg_rd_data[6] |=> fault_sources[1]
      ##1 !fault_indicator_out_n) else $error("crc report");
  pos_gate_a:
    assert property ($rose(fault_sources[2]) |->
      $past(pos_detect_timeout && cfg_rd_data[2])) else $error("pos gate");
  rate_set_a:
    assert property (pos_detect_rate_err && cfg_rd_data[1] |=>
      fault_sources[3]) else $error("rate flag");
  sat_off_a:
    assert property (!cfg_rd_data[0] |=> !current_sat_flag && !speed_sat_flag)
      else $error("sat flag shown");
  sat_on_a:
    assert property (cfg_rd_data[0] && current_loop_sat |=> current_sat_flag)
      else $error("sat flag missing");
  lock_off_a:
    assert property (lock_detect && cfg_rd_data[5:3] == 3'h7 &&
      lock_state == 2'd0 |=> lock_state == 2'd0) else $error("lock off");
  lock_rpt_a:
    assert property (lock_detect && cfg_rd_data[5:3] == 3'h6 &&
      lock_state == 2'd0 |=> lock_state == 2'd3 && !fault_indicator_out_n)
      else $error("lock report");
  lock_latch_a:
    assert property (lock_detect && cfg_rd_data[5:3] == 3'h0 &&
      lock_state == 2'd0 |=> lock_state == 2'd2 && stage_tristate)
      else $error("lock latch");
  flag_clear_a:
    assert property (fault_clear && !i2c_crc_err && !pos_detect_timeout &&
      !pos_detect_rate_err |=> fault_sources == 4'h0) else $error("clear");
  // the main paths that the bench must reach
  cover property (lock_state == 2'd1 ##1 lock_state == 2'd0);
  cover property (lock_state == 2'd2 && stage_high_brake);
  cover property (fault_sources[1] && !stage_tristate);
endmodule
bind mfr_fault_response mfr_fault_response_chk u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .cfg_rd_data(cfg_rd_data),
  .fault_clear(fault_clear), .lock_detect(lock_detect),
  .i2c_crc_err(i2c_crc_err), .pos_detect_timeout(pos_detect_timeout),
  .pos_detect_rate_err(pos_detect_rate_err),
  .current_loop_sat(current_loop_sat),
  .fault_indicator_out_n(fault_indicator_out_n),
  .stage_tristate(stage_tristate), .stage_low_brake(stage_low_brake),
  .stage_high_brake(stage_high_brake), .current_sat_flag(current_sat_flag),
  .speed_sat_flag(speed_sat_flag), .lock_state(lock_state),
  .fault_sources(fault_sources));
`default_nettype wire

//--- tb/mfr_host_model.sv
// Purpose: host side writing the config word and clearing faults
// Assumes: drives just after rising sys_clk edges
// Notes:   released data is inverted so a stale word is never reused
`timescale 1ns/1ps
`default_nettype none
module mfr_host_model (
  input  wire logic        sys_clk,
  output logic             wr_en,
  output logic [31:0]      wr_data,
  output logic             clr
);
  // idle at time zero so nothing is taken before reset ends
  initial begin
    wr_en = 1'b0;
    wr_data = 32'h0000_0000;
    clr = 1'b0;
  end
  // one-cycle write strobe with its word
  task automatic write_cfg(input logic [31:0] d);
    @(posedge sys_clk);
    wr_en   <= 1'b1;
    wr_data <= d;
    @(posedge sys_clk);
    wr_en   <= 1'b0;
    wr_data <= ~d;
  endtask
  // one-cycle clear, then room for the outputs to go idle
  task automatic clear();
    @(posedge sys_clk);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
endmodule
`default_nettype wire

//--- tb/mfr_fault_response_tb_top.sv
// Purpose: self-checking bench for the fault response block
// Assumes: short retry timings 30/50/100 cycles
// Notes:   events are one-cycle pulses driven on the rising edge
`timescale 1ns/1ps
`default_nettype none
module mfr_fault_response_tb_top;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        wr_en, clr, ind_n, csat, ssat;
  logic        cur_sat = 1'b0;
  logic        spd_sat = 1'b0;
  logic [31:0] wr_data, rd;
  logic [3:0]  limit = 4'h0;
  logic [3:0]  ev = 4'h0;
  logic [3:0]  rcnt, fsrc;
  logic [2:0]  st;
  logic [1:0]  ls;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          cyc = 0;

  // 25 ns period
  always #12.5 sys_clk = ~sys_clk;

  mfr_host_model u_host (.sys_clk(sys_clk), .wr_en(wr_en),
    .wr_data(wr_data), .clr(clr));
  mfr_fault_response #(.RETRY_T0_CYC(30), .RETRY_T1_CYC(50),
    .RETRY_STEP_CYC(100)) DUT (
    .sys_clk(sys_clk), .rst_n(rst_n), .cfg_wr_en(wr_en),
    .cfg_wr_data(wr_data), .cfg_rd_data(rd), .retry_count_limit(limit),
    .fault_clear(clr), .lock_detect(ev[3]), .i2c_crc_err(ev[2]),
    .pos_detect_timeout(ev[1]), .pos_detect_rate_err(ev[0]),
    .current_loop_sat(cur_sat), .speed_loop_sat(spd_sat),
    .fault_indicator_out_n(ind_n), .stage_tristate(st[2]),
    .stage_low_brake(st[1]), .stage_high_brake(st[0]),
    .current_sat_flag(csat), .speed_sat_flag(ssat), .retry_count(rcnt),
    .lock_state(ls), .fault_sources(fsrc));

  task automatic end_sim();
    if (n_mismatch == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  // stage pattern, indicator and lock state in one call
  task automatic out(input logic [2:0] es, input logic ei,
                     input logic [1:0] el);
    chk("stage", 32'(st), 32'(es));
    chk("indicator_n", 32'(ind_n), 32'(ei));
    chk("lock_state", 32'(ls), 32'(el));
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // one-cycle event, then enough edges for the latch kinds to land
  task automatic pulse(input logic [3:0] m);
    @(posedge sys_clk);
    ev <= m;
    @(posedge sys_clk);
    ev <= 4'h0;
    wt(3);
  endtask

  function automatic logic [31:0] cw(input logic [3:0] r, input logic c,
                                     input logic [2:0] m, p);
    return {21'h0, r, c, m, p};
  endfunction

  // hang guard, far above the few hundred cycles the tests need
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      end_sim();
    end
  end

  // main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    chk("cfg_rd_data", rd, 32'h0000_0000);
    out(3'b000, 1'b1, 2'd0);
    u_host.write_cfg(32'hffff_ffff);
    wt(1);
    chk("cfg_rd_data", rd, 32'h0000_07ff);
    u_host.write_cfg(cw(4'h0, 1'b0, 3'h7, 3'h0));
    pulse(4'h4);
    out(3'b100, 1'b0, 2'd0);
    chk("fault_sources", 32'(fsrc), 32'h1);
    wt(8);
    out(3'b100, 1'b0, 2'd0);
    u_host.clear();
    out(3'b000, 1'b1, 2'd0);
    u_host.write_cfg(cw(4'h0, 1'b1, 3'h7, 3'h0));
    pulse(4'h4);
    out(3'b000, 1'b0, 2'd0);
    u_host.clear();
    for (int m = 0; m < 3; m++) begin
      u_host.write_cfg(cw(4'h0, 1'b0, 3'(m), 3'h0));
      pulse(4'h8);
      out(3'b100 >> m, 1'b0, 2'd2);
      u_host.clear();
    end
    @(posedge sys_clk);
    limit <= 4'h1;
    u_host.write_cfg(cw(4'h0, 1'b0, 3'h3, 3'h0));
    pulse(4'h8);
    out(3'b100, 1'b0, 2'd1);
    chk("retry_count", 32'(rcnt), 32'h1);
    wt(20);
    chk("lock_state", 32'(ls), 32'h1);
    wt(15);
    out(3'b000, 1'b1, 2'd0);
    pulse(4'h8);
    out(3'b100, 1'b0, 2'd2);
    u_host.clear();
    u_host.write_cfg(cw(4'h2, 1'b0, 3'h4, 3'h0));
    pulse(4'h8);
    out(3'b010, 1'b0, 2'd1);
    wt(90);
    chk("lock_state", 32'(ls), 32'h1);
    wt(15);
    out(3'b000, 1'b1, 2'd0);
    u_host.clear();
    @(posedge sys_clk);
    limit <= 4'h0;
    u_host.write_cfg(cw(4'h1, 1'b0, 3'h5, 3'h0));
    pulse(4'h8);
    out(3'b001, 1'b0, 2'd2);
    u_host.clear();
    u_host.write_cfg(cw(4'h0, 1'b0, 3'h6, 3'h0));
    pulse(4'h8);
    out(3'b000, 1'b0, 2'd3);
    u_host.clear();
    u_host.write_cfg(cw(4'h0, 1'b0, 3'h7, 3'h0));
    pulse(4'h8);
    out(3'b000, 1'b1, 2'd0);
    pulse(4'h3);
    chk("fault_sources", 32'(fsrc), 32'h0);
    u_host.write_cfg(cw(4'h0, 1'b0, 3'h7, 3'h4));
    pulse(4'h2);
    chk("fault_sources", 32'(fsrc), 32'h4);
    u_host.clear();
    u_host.write_cfg(cw(4'h0, 1'b0, 3'h7, 3'h2));
    pulse(4'h1);
    chk("fault_sources", 32'(fsrc), 32'h8);
    u_host.clear();
    @(posedge sys_clk);
    cur_sat <= 1'b1;
    spd_sat <= 1'b1;
    wt(2);
    chk("sat_flags", 32'({csat, ssat}), 32'h0);
    u_host.write_cfg(cw(4'h0, 1'b0, 3'h7, 3'h1));
    wt(2);
    chk("sat_flags", 32'({csat, ssat}), 32'h3);
    end_sim();
  end
endmodule
`default_nettype wire
